// ==== common/intc_defs.svh ====
// constants for the four-level interrupt controller
// assumes: included by bare name from package and design files
`ifndef INTC_DEFS_SVH
`define INTC_DEFS_SVH

// machine cycle length in cpu clocks, source count and top level
`define MC_CLOCKS 6
`define NUM_SRC 12
`define TOP_LEVEL 2'h3
`define GLOBAL_EN_BIT 7

// arbitration rank of each source, 0 wins ties
`define RANK_EXT0 4'h0
`define RANK_BROWNOUT 4'h1
`define RANK_WATCHDOG 4'h2
`define RANK_TIMER_A 4'h3
`define RANK_TWO_WIRE 4'h4
`define RANK_EXT1 4'h5
`define RANK_KEYPAD 4'h6
`define RANK_COMP_A 4'h7
`define RANK_TIMER_B 4'h8
`define RANK_COMP_B 4'h9
`define RANK_SERIAL 4'hA
`define RANK_INT_TIMER 4'hB

// enable and priority bit position in {reg_b, reg_a}
`define POS_EXT0 4'h0
`define POS_TIMER_A 4'h1
`define POS_EXT1 4'h2
`define POS_TIMER_B 4'h3
`define POS_SERIAL 4'h4
`define POS_BROWNOUT 4'h5
`define POS_WATCHDOG 4'h6
`define POS_TWO_WIRE 4'h8
`define POS_KEYPAD 4'h9
`define POS_COMP_B 4'hA
`define POS_COMP_A 4'hD
`define POS_INT_TIMER 4'hF

// vector addresses
`define VEC_NONE 16'h0000
`define VEC_EXT0 16'h0003
`define VEC_TIMER_A 16'h000B
`define VEC_EXT1 16'h0013
`define VEC_TIMER_B 16'h001B
`define VEC_SERIAL 16'h0023
`define VEC_BROWNOUT 16'h002B
`define VEC_TWO_WIRE 16'h0033
`define VEC_KEYPAD 16'h003B
`define VEC_COMP_B 16'h0043
`define VEC_WATCHDOG 16'h0053
`define VEC_COMP_A 16'h0063
`define VEC_INT_TIMER 16'h0073

// power-down wake capability, indexed by rank
`define WAKE_MASK 12'h2E7

`endif

// ==== common/intc_pkg.sv ====
// types shared by the interrupt controller files
// assumes: intc_defs.svh on the include path
`include "intc_defs.svh"
package intc_pkg;
   typedef logic [1:0] level_t;
   typedef logic [3:0] src_idx_t;
   typedef logic [15:0] vector_t;

   // request offered to the cpu core
   typedef struct packed {
      logic req;
      vector_t vector;
      level_t level;
      src_idx_t source;
   } cpu_req_t;

   // handshake states, gray along idle-offer-settle
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_OFFER = 2'h1,
      ST_SETTLE = 2'h3
   } hs_state_t;
endpackage : intc_pkg

// ==== hdl/ext_irq_input.sv ====
// one external request pin: machine-cycle sampling, level or edge flag
// assumes: pin synchronous to clk, mc_tick one pulse per machine cycle
`timescale 1ns/10ps
`include "intc_defs.svh"
module ext_irq_input
(
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // sampling and control
   input wire logic mc_tick,
   input wire logic pin_n,
   input wire logic edge_mode,
   input wire logic clear,
   // result
   output logic flag
);
   logic sample_q;
   logic edge_q;

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         sample_q <= 1'b1;
      else if (mc_tick)
         sample_q <= pin_n;
   end

   // high sample then low sample sets flag
   // cleared when vectored; a new edge in that cycle wins
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         edge_q <= 1'b0;
      else if (mc_tick && sample_q && !pin_n)
         edge_q <= 1'b1;
      else if (clear)
         edge_q <= 1'b0;
   end

   // trigger type picks level or edge
   // level flag simply tracks the sampled pin
   assign flag = edge_mode ? edge_q : ~sample_q;
endmodule : ext_irq_input

// ==== hdl/intc_top.sv ====
// four-level interrupt controller with vectoring and wake logic
// assumes: cpu pulses CPU_ACK while a request is offered and CPU_RETI
// on return; all inputs synchronous to CLOCK
`timescale 1ns/10ps
`include "intc_defs.svh"

module intc_top
   import intc_pkg::*;
#(
   parameter int MC_CLOCKS = `MC_CLOCKS
)
(
   // clock and reset
   input wire logic CLOCK,
   input wire logic RSTN,
   // enable and priority registers
   input wire logic [7:0] IRQ_ENABLE_REG_A,
   input wire logic [7:0] IRQ_ENABLE_REG_B,
   input wire logic [7:0] PRIO_LOW_REG_A,
   input wire logic [7:0] PRIO_HIGH_REG_A,
   input wire logic [7:0] PRIO_LOW_REG_B,
   input wire logic [7:0] PRIO_HIGH_REG_B,
   // external trigger types, bit 0 for ext 0
   input wire logic [1:0] EXT_TRIGGER_TYPE,
   // external request pins, active low
   input wire logic [1:0] EXT_REQUEST_PIN_N,
   // peripheral flags
   input wire logic TIMER_A_OVERFLOW_FLAG,
   input wire logic TIMER_B_OVERFLOW_FLAG,
   input wire logic SERIAL_TX_DONE_FLAG,
   input wire logic SERIAL_RX_DONE_FLAG,
   input wire logic BROWNOUT_FLAG,
   input wire logic TWO_WIRE_ATTENTION_FLAG,
   input wire logic KEYPAD_FLAG,
   input wire logic COMPARATOR_A_FLAG,
   input wire logic COMPARATOR_B_FLAG,
   input wire logic WATCHDOG_OVERFLOW_FLAG,
   input wire logic INT_TIMER_REQ,
   // power modes
   input wire logic IDLE_MODE,
   input wire logic POWER_DOWN_MODE,
   // cpu core
   input wire logic CPU_ACK,
   input wire logic CPU_RETI,
   output cpu_req_t CPU_REQ,
   output logic [3:0] ACTIVE_LEVELS,
   output logic [1:0] EXT_REQUEST_FLAG,
   output logic WAKE
);
   localparam int MCW = (MC_CLOCKS > 1) ? $clog2(MC_CLOCKS) : 1;
   localparam logic [MCW-1:0] MC_LAST = MCW'(MC_CLOCKS - 1);

   logic [MCW-1:0] mc_cnt_q;
   logic mc_tick;
   logic [15:0] enable_bits;
   logic [15:0] prio_hi_bits;
   logic [15:0] prio_lo_bits;
   logic global_irq_enable;
   logic [1:0] ext_request_flag;
   logic [1:0] ext_clear;
   logic [`NUM_SRC-1:0] src_flag;
   logic [`NUM_SRC-1:0] pending;
   logic best_valid;
   src_idx_t best_idx;
   level_t best_lvl;
   logic any_active;
   level_t cur_lvl;
   logic can_take;
   logic taken;
   hs_state_t state_q;
   hs_state_t state_d;
   cpu_req_t req_q;
   cpu_req_t req_d;
   logic [3:0] active_q;
   logic wake_q;

   // bit position of a source in the enable and priority words
   function automatic logic [3:0] src_pos(input src_idx_t idx);
      logic [3:0] p;
      p = `POS_EXT0;
      case (idx)
         `RANK_EXT0: p = `POS_EXT0;
         `RANK_BROWNOUT: p = `POS_BROWNOUT;
         `RANK_WATCHDOG: p = `POS_WATCHDOG;
         `RANK_TIMER_A: p = `POS_TIMER_A;
         `RANK_TWO_WIRE: p = `POS_TWO_WIRE;
         `RANK_EXT1: p = `POS_EXT1;
         `RANK_KEYPAD: p = `POS_KEYPAD;
         `RANK_COMP_A: p = `POS_COMP_A;
         `RANK_TIMER_B: p = `POS_TIMER_B;
         `RANK_COMP_B: p = `POS_COMP_B;
         `RANK_SERIAL: p = `POS_SERIAL;
         `RANK_INT_TIMER: p = `POS_INT_TIMER;
         default: p = `POS_EXT0;
      endcase
      return p;
   endfunction : src_pos

   function automatic vector_t src_vector(input src_idx_t idx);
      vector_t v;
      v = `VEC_NONE;
      case (idx)
         `RANK_EXT0: v = `VEC_EXT0;
         `RANK_BROWNOUT: v = `VEC_BROWNOUT;
         `RANK_WATCHDOG: v = `VEC_WATCHDOG;
         `RANK_TIMER_A: v = `VEC_TIMER_A;
         `RANK_TWO_WIRE: v = `VEC_TWO_WIRE;
         `RANK_EXT1: v = `VEC_EXT1;
         `RANK_KEYPAD: v = `VEC_KEYPAD;
         `RANK_COMP_A: v = `VEC_COMP_A;
         `RANK_TIMER_B: v = `VEC_TIMER_B;
         `RANK_COMP_B: v = `VEC_COMP_B;
         `RANK_SERIAL: v = `VEC_SERIAL;
         `RANK_INT_TIMER: v = `VEC_INT_TIMER;
         default: v = `VEC_NONE;
      endcase
      return v;
   endfunction : src_vector

   // level from the two priority bits at one position
   function automatic level_t src_level(input src_idx_t idx, input logic [15:0] hi,
                                        input logic [15:0] lo);
      logic [3:0] p;
      p = src_pos(idx);
      return {hi[p], lo[p]};
   endfunction : src_level

   assign enable_bits = {IRQ_ENABLE_REG_B, IRQ_ENABLE_REG_A};
   assign prio_hi_bits = {PRIO_HIGH_REG_B, PRIO_HIGH_REG_A};
   assign prio_lo_bits = {PRIO_LOW_REG_B, PRIO_LOW_REG_A};
   assign global_irq_enable = IRQ_ENABLE_REG_A[`GLOBAL_EN_BIT];

   // machine cycle strobe for pin sampling
   always_ff @(posedge CLOCK or negedge RSTN)
   begin
      if (!RSTN)
         mc_cnt_q <= '0;
      else if (mc_cnt_q == MC_LAST)
         mc_cnt_q <= '0;
      else
         mc_cnt_q <= mc_cnt_q + MCW'(1);
   end
   // one sample per machine cycle relies on six-clock levels
   assign mc_tick = (mc_cnt_q == MC_LAST);

   // clear edge flag when its own vector is taken
   assign ext_clear[0] = taken && (req_q.source == `RANK_EXT0);
   assign ext_clear[1] = taken && (req_q.source == `RANK_EXT1);

   genvar g;
   generate
      for (g = 0; g < 2; g++)
      begin : g_ext
         // edge needs a high then a low machine-cycle sample
         ext_irq_input u_ext
         (
            .clk(CLOCK),
            .rstn(RSTN),
            .mc_tick(mc_tick),
            .pin_n(EXT_REQUEST_PIN_N[g]),
            .edge_mode(EXT_TRIGGER_TYPE[g]),
            .clear(ext_clear[g]),
            .flag(ext_request_flag[g])
         );
      end
   endgenerate

   // twelve request sources in rank order
   // serial request from either done flag
   always_comb
   begin
      src_flag = '0;
      src_flag[`RANK_EXT0] = ext_request_flag[0];
      src_flag[`RANK_BROWNOUT] = BROWNOUT_FLAG;
      src_flag[`RANK_WATCHDOG] = WATCHDOG_OVERFLOW_FLAG;
      src_flag[`RANK_TIMER_A] = TIMER_A_OVERFLOW_FLAG;
      src_flag[`RANK_TWO_WIRE] = TWO_WIRE_ATTENTION_FLAG;
      src_flag[`RANK_EXT1] = ext_request_flag[1];
      src_flag[`RANK_KEYPAD] = KEYPAD_FLAG;
      src_flag[`RANK_COMP_A] = COMPARATOR_A_FLAG;
      src_flag[`RANK_TIMER_B] = TIMER_B_OVERFLOW_FLAG;
      src_flag[`RANK_COMP_B] = COMPARATOR_B_FLAG;
      src_flag[`RANK_SERIAL] = SERIAL_TX_DONE_FLAG | SERIAL_RX_DONE_FLAG;
      src_flag[`RANK_INT_TIMER] = INT_TIMER_REQ;
   end

   // individual enable and global enable gate each source
   always_comb
   begin
      pending = '0;
      for (int i = 0; i < `NUM_SRC; i++)
         pending[i] = src_flag[i] & enable_bits[src_pos(4'(i))] & global_irq_enable;
   end

   // strict compare keeps the lower rank on a tie
   always_comb
   begin
      best_valid = 1'b0;
      best_idx = '0;
      best_lvl = '0;
      for (int i = 0; i < `NUM_SRC; i++)
      begin
         if (pending[i] &&
             (!best_valid || src_level(4'(i), prio_hi_bits, prio_lo_bits) > best_lvl))
         begin
            best_valid = 1'b1;
            best_idx = 4'(i);
            best_lvl = src_level(4'(i), prio_hi_bits, prio_lo_bits);
         end
      end
   end

   // highest level currently in service
   always_comb
   begin
      any_active = |active_q;
      cur_lvl = '0;
      for (int l = 0; l < 4; l++)
      begin
         if (active_q[l])
            cur_lvl = 2'(l);
      end
   end

   // strictly higher level needed to preempt
   // nothing exceeds the top level, so it is never preempted
   assign can_take = best_valid && (!any_active || (best_lvl > cur_lvl));
   assign taken = (state_q == ST_OFFER) && CPU_ACK;

   // offer handshake; settle lets flags and levels update before re-arbitrating
   always_comb
   begin
      state_d = state_q;
      req_d = req_q;
      case (state_q)
         ST_IDLE:
         begin
            if (can_take && !CPU_RETI)
            begin
               state_d = ST_OFFER;
               req_d = '{req: 1'b1, vector: src_vector(best_idx), level: best_lvl,
                         source: best_idx};
            end
         end
         ST_OFFER:
         begin
            if (CPU_ACK || CPU_RETI)
            begin
               state_d = ST_SETTLE;
               req_d.req = 1'b0;
            end
            else if (!can_take)
            begin
               state_d = ST_IDLE;
               req_d.req = 1'b0;
            end
            else
               req_d = '{req: 1'b1, vector: src_vector(best_idx), level: best_lvl,
                         source: best_idx};
         end
         ST_SETTLE:
            state_d = ST_IDLE;
         default:
         begin
            state_d = ST_IDLE;
            req_d.req = 1'b0;
         end
      endcase
   end

   always_ff @(posedge CLOCK or negedge RSTN)
   begin
      if (!RSTN)
         state_q <= ST_IDLE;
      else
         state_q <= state_d;
   end

   always_ff @(posedge CLOCK or negedge RSTN)
   begin
      if (!RSTN)
         req_q <= '{req: 1'b0, vector: `VEC_NONE, level: 2'h0, source: 4'h0};
      else
         req_q <= req_d;
   end

   // mark level on vectoring, release highest on return
   // a still-low level pin is offered again once released
   always_ff @(posedge CLOCK or negedge RSTN)
   begin
      if (!RSTN)
         active_q <= 4'h0;
      else if (taken)
         active_q[req_q.level] <= 1'b1;
      else if (CPU_RETI && any_active)
         active_q[cur_lvl] <= 1'b0;
   end

   // power down wakes only on capable sources
   // idle wakes on any enabled pending request
   always_ff @(posedge CLOCK or negedge RSTN)
   begin
      if (!RSTN)
         wake_q <= 1'b0;
      else
         wake_q <= (POWER_DOWN_MODE && |(pending & `WAKE_MASK)) ||
                   (IDLE_MODE && |pending);
   end

   assign CPU_REQ = req_q;
   assign ACTIVE_LEVELS = active_q;
   assign EXT_REQUEST_FLAG = ext_request_flag;
   assign WAKE = wake_q;
endmodule : intc_top

// ==== testbench/intc_props.sv ====
// port assertions for the interrupt controller
// assumes: bound to intc_top, one clock domain
`timescale 1ns/10ps
module intc_props
   import intc_pkg::*;
(
   // clock and reset
   input wire logic CLOCK,
   input wire logic RSTN,
   // inputs
   input wire logic [1:0] EXT_TRIGGER_TYPE,
   input wire logic [1:0] EXT_REQUEST_PIN_N,
   input wire logic IDLE_MODE,
   input wire logic POWER_DOWN_MODE,
   input wire logic CPU_ACK,
   // outputs
   input wire cpu_req_t CPU_REQ,
   input wire logic [3:0] ACTIVE_LEVELS,
   input wire logic [1:0] EXT_REQUEST_FLAG,
   input wire logic WAKE
);
   localparam logic [15:0] VT [12] = '{16'h0003, 16'h002B, 16'h0053, 16'h000B,
      16'h0033, 16'h0013, 16'h003B, 16'h0063, 16'h001B, 16'h0043, 16'h0023, 16'h0073};
   wire logic take = CPU_REQ.req && CPU_ACK;
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (!RSTN);
   property p_ack_drop;
      take |=> !CPU_REQ.req;
   endproperty
   a_ack_drop: assert property (p_ack_drop) else $error("offer after ack");
   property p_ack_lvl;
      take |=> ACTIVE_LEVELS[$past(CPU_REQ.level)];
   endproperty
   a_ack_lvl: assert property (p_ack_lvl) else $error("level not active");
   property p_edge_clr;
      // pin high at the ack edge, so no fresh edge can set the flag again
      take && CPU_REQ.source == 4'h0 && EXT_TRIGGER_TYPE[0] && EXT_REQUEST_PIN_N[0]
         |=> !EXT_REQUEST_FLAG[0];
   endproperty
   a_edge_clr: assert property (p_edge_clr) else $error("edge flag kept");
   property p_preempt;
      CPU_REQ.req |-> (ACTIVE_LEVELS >> CPU_REQ.level) == 4'h0;
   endproperty
   a_preempt: assert property (p_preempt) else $error("offer not higher");
   property p_top;
      ACTIVE_LEVELS[3] |-> !CPU_REQ.req;
   endproperty
   a_top: assert property (p_top) else $error("top level preempted");
   property p_vector;
      CPU_REQ.req |-> CPU_REQ.vector == VT[CPU_REQ.source];
   endproperty
   a_vector: assert property (p_vector) else $error("bad vector");
   property p_wake;
      !POWER_DOWN_MODE && !IDLE_MODE |=> !WAKE;
   endproperty
   a_wake: assert property (p_wake) else $error("wake while running");
   // covers pin-to-flag delay plus register
   property p_level;
      (!EXT_TRIGGER_TYPE[1] && EXT_REQUEST_PIN_N[1]) [*8] |-> !EXT_REQUEST_FLAG[1];
   endproperty
   a_level: assert property (p_level) else $error("level flag stuck");
   c_take: cover property (take);
   c_wake: cover property (WAKE);
   c_edge: cover property (EXT_REQUEST_FLAG[0] && EXT_TRIGGER_TYPE[0]);
endmodule : intc_props
bind intc_top intc_props intc_props_inst (.CLOCK(CLOCK), .RSTN(RSTN),
   .EXT_TRIGGER_TYPE(EXT_TRIGGER_TYPE), .EXT_REQUEST_PIN_N(EXT_REQUEST_PIN_N),
   .IDLE_MODE(IDLE_MODE), .POWER_DOWN_MODE(POWER_DOWN_MODE), .CPU_ACK(CPU_ACK),
   .CPU_REQ(CPU_REQ), .ACTIVE_LEVELS(ACTIVE_LEVELS),
   .EXT_REQUEST_FLAG(EXT_REQUEST_FLAG), .WAKE(WAKE));

// ==== testbench/cpu_model.sv ====
// cpu core stand-in: takes an offered request after a set delay
// assumes: bench owns go and delay, acts on the falling edge
`timescale 1ns/10ps
module cpu_model
   import intc_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // controller side
   input wire cpu_req_t req,
   output logic ack,
   // bench side
   input wire logic go,
   input wire logic [3:0] delay,
   output logic took
);
   logic [3:0] wait_q;
   logic go_q;
   always @(negedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         ack <= 1'b0;
         wait_q <= 4'h0;
      end
      else
      begin
         wait_q <= (req.req && go_q) ? wait_q + 4'h1 : 4'h0;
         ack <= req.req && go_q && wait_q >= delay;
      end
   end
   // go re-timed on the rising edge: bench writes it on the falling one
   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         took <= 1'b0;
         go_q <= 1'b0;
      end
      else
      begin
         took <= ack && req.req;
         go_q <= go;
      end
   end
endmodule : cpu_model

// ==== testbench/intc_top_tb.sv ====
// bench for the interrupt controller, one task a scenario
// assumes: cpu_model answers acks; pins and flags driven here
`timescale 1ns/10ps
module intc_top_tb
   import intc_pkg::*;
;
   localparam int POS [12] = '{0, 5, 6, 1, 8, 2, 9, 13, 3, 10, 4, 15};
   // vector per source, in rank order
   localparam logic [15:0] VEC [12] = '{16'h0003, 16'h002B, 16'h0053, 16'h000B,
      16'h0033, 16'h0013, 16'h003B, 16'h0063, 16'h001B, 16'h0043, 16'h0023, 16'h0073};
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [15:0] en = 16'hFFFF;
   logic [15:0] plo = 16'h0000;
   logic [15:0] phi = 16'h0000;
   logic [1:0] trig = 2'h0;
   logic [1:0] pin_n = 2'h3;
   logic [11:0] flg = 12'h000;
   logic rx = 1'b0;
   logic idle = 1'b0;
   logic pdn = 1'b0;
   logic reti = 1'b0;
   logic go = 1'b0;
   logic [3:0] dly = 4'h0;
   logic ack;
   logic took;
   logic wake;
   logic [3:0] act;
   logic [1:0] xf;
   cpu_req_t req;
   int error_cnt = 0;
   int tests_run = 0;
   always #25 clk = ~clk;
   intc_top #(.MC_CLOCKS(6)) intc_top_inst (.CLOCK(clk), .RSTN(rstn),
      .IRQ_ENABLE_REG_A(en[7:0]), .IRQ_ENABLE_REG_B(en[15:8]),
      .PRIO_LOW_REG_A(plo[7:0]), .PRIO_HIGH_REG_A(phi[7:0]),
      .PRIO_LOW_REG_B(plo[15:8]), .PRIO_HIGH_REG_B(phi[15:8]),
      .EXT_TRIGGER_TYPE(trig), .EXT_REQUEST_PIN_N(pin_n),
      .TIMER_A_OVERFLOW_FLAG(flg[3]), .TIMER_B_OVERFLOW_FLAG(flg[8]),
      .SERIAL_TX_DONE_FLAG(flg[10]), .SERIAL_RX_DONE_FLAG(rx),
      .BROWNOUT_FLAG(flg[1]), .TWO_WIRE_ATTENTION_FLAG(flg[4]),
      .KEYPAD_FLAG(flg[6]), .COMPARATOR_A_FLAG(flg[7]),
      .COMPARATOR_B_FLAG(flg[9]), .WATCHDOG_OVERFLOW_FLAG(flg[2]),
      .INT_TIMER_REQ(flg[11]), .IDLE_MODE(idle), .POWER_DOWN_MODE(pdn),
      .CPU_ACK(ack), .CPU_RETI(reti), .CPU_REQ(req), .ACTIVE_LEVELS(act),
      .EXT_REQUEST_FLAG(xf), .WAKE(wake));
   cpu_model cpu_model_inst (.clk(clk), .rstn(rstn), .req(req), .ack(ack),
      .go(go), .delay(dly), .took(took));
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : wrap_up
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask : cyc
   // pins held until serve sees the offer taken
   task automatic src(input int r, input logic v);
      if (r == 0)
         pin_n[0] = ~v;
      else if (r == 5)
         pin_n[1] = ~v;
      else
         flg[r] = v;
   endtask : src
   task automatic lvl(input int r, input logic [1:0] l);
      phi[POS[r]] = l[1];
      plo[POS[r]] = l[0];
   endtask : lvl
   task automatic serve(input int r);
      int n;
      n = 0;
      while (req.req !== 1'b1 && n < 40)
      begin
         cyc(1);
         n++;
      end
      chk("source", 16'(r), {12'h000, req.source});
      chk("vector", VEC[r], req.vector);
      go = 1'b1;
      n = 0;
      while (took !== 1'b1 && n < 40)
      begin
         cyc(1);
         n++;
      end
      go = 1'b0;
      chk("taken", 16'h0001, {15'h0000, took});
   endtask : serve
   task automatic quiet(input int n);
      int seen;
      seen = 0;
      repeat (n)
      begin
         cyc(1);
         if (req.req !== 1'b0)
            seen++;
      end
      chk("no offer", 16'h0000, 16'(seen));
   endtask : quiet
   task automatic ret;
      reti = 1'b1;
      cyc(1);
      reti = 1'b0;
      cyc(2);
   endtask : ret
   task automatic t_vectors;
      chk("reset outputs", 16'h0000, {req.req, act, xf, wake, 8'h00});
      for (int r = 0; r < 12; r++)
      begin
         src(r, 1'b1);
         serve(r);
         src(r, 1'b0);
         cyc(10);
         ret();
      end
      rx = 1'b1;
      serve(10);
      rx = 1'b0;
      ret();
      $display("test vectors done");
   endtask : t_vectors
   task automatic t_arbit;
      lvl(10, 2'h2);
      lvl(3, 2'h1);
      flg = 12'h408;
      serve(10);
      chk("level", 16'h0002, {14'h0000, req.level});
      flg[10] = 1'b0;
      quiet(20);
      ret();
      serve(3);
      flg[3] = 1'b0;
      ret();
      plo = 16'h0000;
      phi = 16'h0000;
      flg = 12'h408;
      serve(3);
      flg[3] = 1'b0;
      quiet(20);
      ret();
      serve(10);
      flg[10] = 1'b0;
      ret();
      $display("test arbitration done");
   endtask : t_arbit
   task automatic t_preempt;
      lvl(3, 2'h1);
      lvl(7, 2'h1);
      lvl(1, 2'h2);
      lvl(2, 2'h3);
      lvl(6, 2'h3);
      dly = 4'h3;
      flg[3] = 1'b1;
      serve(3);
      flg = 12'h080;
      quiet(12);
      flg[1] = 1'b1;
      serve(1);
      flg[1] = 1'b0;
      flg[2] = 1'b1;
      serve(2);
      flg[2] = 1'b0;
      flg[6] = 1'b1;
      quiet(12);
      chk("active", 16'h000E, {12'h000, act});
      ret();
      serve(6);
      flg[6] = 1'b0;
      ret();
      ret();
      quiet(12);
      ret();
      serve(7);
      flg[7] = 1'b0;
      ret();
      chk("active", 16'h0000, {12'h000, act});
      dly = 4'h0;
      $display("test preemption done");
   endtask : t_preempt
   task automatic t_enable;
      en[7] = 1'b0;
      flg[3] = 1'b1;
      quiet(12);
      en[7] = 1'b1;
      en[1] = 1'b0;
      quiet(12);
      en[1] = 1'b1;
      serve(3);
      flg[3] = 1'b0;
      ret();
      $display("test enables done");
   endtask : t_enable
   task automatic t_pins;
      trig[0] = 1'b1;
      cyc(12);
      // low then back high, eight clocks each
      pin_n[0] = 1'b0;
      cyc(8);
      pin_n[0] = 1'b1;
      cyc(8);
      chk("edge flag", 16'h0001, {15'h0000, xf[0]});
      serve(0);
      chk("edge flag", 16'h0000, {15'h0000, xf[0]});
      ret();
      trig[0] = 1'b0;
      pin_n[1] = 1'b0;
      serve(5);
      chk("level flag", 16'h0001, {15'h0000, xf[1]});
      quiet(12);
      ret();
      serve(5);
      pin_n[1] = 1'b1;
      cyc(10);
      chk("level flag", 16'h0000, {15'h0000, xf[1]});
      ret();
      trig[1] = 1'b1;
      // low then back high on the second pin too
      pin_n[1] = 1'b0;
      cyc(8);
      pin_n[1] = 1'b1;
      cyc(8);
      chk("edge flag", 16'h0001, {15'h0000, xf[1]});
      serve(5);
      chk("edge flag", 16'h0000, {15'h0000, xf[1]});
      ret();
      trig[1] = 1'b0;
      $display("test pins done");
   endtask : t_pins
   task automatic t_wake;
      pdn = 1'b1;
      flg[3] = 1'b1;
      cyc(4);
      chk("wake", 16'h0000, {15'h0000, wake});
      flg[6] = 1'b1;
      cyc(4);
      chk("wake", 16'h0001, {15'h0000, wake});
      flg = 12'h000;
      pin_n[0] = 1'b0;
      cyc(10);
      chk("wake", 16'h0001, {15'h0000, wake});
      pin_n[0] = 1'b1;
      pdn = 1'b0;
      idle = 1'b1;
      pin_n[1] = 1'b0;
      cyc(10);
      chk("wake", 16'h0001, {15'h0000, wake});
      pin_n[1] = 1'b1;
      idle = 1'b0;
      cyc(12);
      $display("test wake done");
   endtask : t_wake
   initial
   begin
      cyc(6);
      rstn = 1'b1;
      cyc(2);
      t_vectors();
      t_arbit();
      t_preempt();
      t_enable();
      t_pins();
      t_wake();
      wrap_up();
   end
   initial
   begin
      cyc(20000);
      error_cnt++;
      $display("ERROR watchdog expected finish seen timeout");
      wrap_up();
   end
endmodule : intc_top_tb
